// ### serial_format_regs.vh
// Contract
// - Output rate code 00/01/10/11 keeps every 1st/2nd/4th/8th sample word.
// - Gate bit 15 of phase register enables bits 6, 5 and 3; else ignored.
// - Phase field resets to 10 internally but reads back 00 until written.
// - Once the phase field is written, readback returns the last written value.
// - Phase field sets bit clock phase against the frame clock rising edge.
// - Sync pattern replaces every channel with repeating 16-bit word FF00.
// - Deskew pattern replaces every channel with alternating one-zero bits.
// - Serialization enable bit 15 gates all other serialization control bits.
// - Width eighteen select serializes data bits 17 down to 0.
// - Width sixteen select serializes data bits 15 down to 0.
// - Width fourteen select serializes data bits 13 down to 0.
// - Padding appends two zero bits below the least significant data bit.
// - Bit order 1 sends most significant bit first, 0 least significant first.
// - Format bit 1 gives two's complement, 0 gives offset binary.
// - Lane mode 1 is two lanes per channel, half-rate frame; 0 single lane.
// - Map group enable activates byte mapping for lanes 1A, 1B, 2A only.
// - Map code with top bit 0: bits 2:1 pick channel, bit 0 low byte.
// - Map code with top bit 1 powers down that lane driver.
// - Lane 1B map sits in bits 7:4, lane 2A in bits 11:8.
`ifndef SERIAL_FORMAT_REGS_VH
`define SERIAL_FORMAT_REGS_VH

`define IDX_OUT_RATE      8'h38
`define IDX_PHASE_REF     8'h42
`define IDX_TEST_PATTERN  8'h45
`define IDX_SERIAL_FORMAT 8'h46
`define IDX_LANE_MAP1     8'h50
`define IDX_STATUS        8'h60

`define BIT_GATE          15
`define BIT_PHASE_HI      6
`define BIT_PHASE_LO      5
`define BIT_EXT_REF       3
`define BIT_SYNC          1
`define BIT_DESKEW        0
`define BIT_W18           12
`define BIT_W16           11
`define BIT_W14           10
`define BIT_PAD           5
`define BIT_MSB_FIRST     3
`define BIT_TWOS          2
`define BIT_TWO_WIRE      0

`define RST_OUT_RATE      2'h0
`define RST_PHASE         2'h2
`define DEF_PHASE         2'h2
`define RST_MAP1          16'h0000
`define DEF_MAP_1A        4'h0
`define DEF_MAP_1B        4'h1
`define DEF_MAP_2A        4'h2
`define DEF_WIDTH         5'd16
`define DEF_MSB_FIRST     1'b1
`define DEF_TWOS          1'b0
`define SYNC_WORD         20'h0FF00
`define DESKEW_WORD       20'hAAAAA
`define PHASE_STEP_CYCLES 2

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### bit_sync.v
`timescale 1ns/10ps
`default_nettype none

module bit_sync
(
	// Clock and reset
	input  wire clk,
	input  wire reset,
	// Asynchronous level in, synchronised level out
	input  wire din,
	output reg  dout_q
);

	reg meta_q;

	// The first stage feeds only the second stage.
	always @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= 1'b0;
			dout_q <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			dout_q <= meta_q;
		end
	end

endmodule // bit_sync

`default_nettype wire

// ### lane_shifter.v
`timescale 1ns/10ps
`default_nettype none

module lane_shifter
(
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	// Bit tick and word load
	input  wire        tick,
	input  wire        load,
	input  wire [19:0] word,
	// Serial bit
	output reg         bit_q
);

	reg [19:0] shift_q;

	// Words arrive left aligned, so bit 19 always leaves first.
	always @(posedge clk)
	begin
		if (reset)
		begin
			shift_q <= 20'h00000;
			bit_q   <= 1'b0;
		end
		else if (tick)
		begin
			if (load)
			begin
				bit_q   <= word[19];
				shift_q <= {word[18:0], 1'b0};
			end
			else
			begin
				bit_q   <= shift_q[19];
				shift_q <= {shift_q[18:0], 1'b0};
			end
		end
	end

endmodule // lane_shifter

`default_nettype wire

// ### serial_output_format.v
`timescale 1ns/10ps
`default_nettype none
`include "serial_format_regs.vh"

module serial_output_format
(
	// Clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// AXI4-Lite write address
	input  wire [9:0]  AWADDR,
	input  wire        AWVALID,
	output reg         AWREADY,
	// AXI4-Lite write data
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	input  wire        WVALID,
	output reg         WREADY,
	// AXI4-Lite write response
	output reg  [1:0]  BRESP,
	output reg         BVALID,
	input  wire        BREADY,
	// AXI4-Lite read address
	input  wire [9:0]  ARADDR,
	input  wire        ARVALID,
	output reg         ARREADY,
	// AXI4-Lite read data
	output reg  [31:0] RDATA,
	output reg  [1:0]  RRESP,
	output reg         RVALID,
	input  wire        RREADY,
	// Converter samples
	input  wire        SAMPLE_VALID,
	input  wire [17:0] CH1_DATA,
	input  wire [17:0] CH2_DATA,
	input  wire [17:0] CH3_DATA,
	input  wire [17:0] CH4_DATA,
	// Link timing reference
	input  wire        LINK_CLK,
	// Serial link
	output reg         SERIAL_BIT_CLOCK,
	output reg         FRAME_CLOCK,
	output wire        LANE_1A,
	output wire        LANE_1B,
	output wire        LANE_2A,
	output reg         LANE_1A_EN,
	output reg         LANE_1B_EN,
	output reg         LANE_2A_EN,
	// Reference control
	output reg         EXTERNAL_REFERENCE_SELECT
);

	reg  [1:0]  out_rate_q;
	reg         phase_gate_q;
	reg  [1:0]  phase_q;
	reg         phase_written_q;
	reg         ext_ref_q;
	reg         sync_q;
	reg         deskew_q;
	reg  [15:0] ser_q;
	reg  [15:0] map_q;
	reg         aw_hold_q;
	reg         w_hold_q;
	reg  [9:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg  [17:0] hold_q [0:3];
	reg  [2:0]  rate_cnt_q;
	reg  [6:0]  lk_pipe_q;
	reg         lk_prev_q;
	reg  [4:0]  cnt_q;
	wire        lk_s;
	wire        tick;
	wire        load;
	wire        ser_en;
	wire [1:0]  phase_eff;
	wire [4:0]  n_data;
	wire [4:0]  n_word;
	wire [4:0]  lane_bits;
	wire [4:0]  cnt_d;
	wire [2:0]  rate_mask;
	wire        pad_eff;
	wire        msb_eff;
	wire        twos_eff;
	wire        two_wire;
	wire [3:0]  code_1a;
	wire [3:0]  code_1b;
	wire [3:0]  code_2a;
	wire [19:0] word_1a;
	wire [19:0] word_1b;
	wire [19:0] word_2a;
	reg  [15:0] rd_val;
	reg         rd_ok;
	reg  [15:0] wr_merge;

	// Byte addresses are four times the printed register index.
	wire [9:0] a_rate   = {`IDX_OUT_RATE, 2'b00};
	wire [9:0] a_phase  = {`IDX_PHASE_REF, 2'b00};
	wire [9:0] a_test   = {`IDX_TEST_PATTERN, 2'b00};
	wire [9:0] a_ser    = {`IDX_SERIAL_FORMAT, 2'b00};
	wire [9:0] a_map    = {`IDX_LANE_MAP1, 2'b00};
	wire [9:0] a_status = {`IDX_STATUS, 2'b00};

	// Write channel: address and data are taken in either order.
	wire do_write = aw_hold_q & w_hold_q & ~BVALID;
	wire wr_hit = (aw_addr_q == a_rate) | (aw_addr_q == a_phase) | (aw_addr_q == a_test)
		| (aw_addr_q == a_ser) | (aw_addr_q == a_map) | (aw_addr_q == a_status);

	always @*
	begin
		wr_merge = 16'h0000;
		if (aw_addr_q == a_rate)
			wr_merge = {14'h0000, out_rate_q};
		else if (aw_addr_q == a_phase)
			wr_merge = {phase_gate_q, 8'h00, phase_q, 1'b0, ext_ref_q, 3'h0};
		else if (aw_addr_q == a_test)
			wr_merge = {14'h0000, sync_q, deskew_q};
		else if (aw_addr_q == a_ser)
			wr_merge = ser_q;
		else if (aw_addr_q == a_map)
			wr_merge = map_q;
		if (w_strb_q[0])
			wr_merge[7:0] = w_data_q[7:0];
		if (w_strb_q[1])
			wr_merge[15:8] = w_data_q[15:8];
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			AWREADY         <= 1'b0;
			WREADY          <= 1'b0;
			BVALID          <= 1'b0;
			BRESP           <= `RESP_OKAY;
			aw_hold_q       <= 1'b0;
			w_hold_q        <= 1'b0;
			aw_addr_q       <= 10'h000;
			w_data_q        <= 32'h00000000;
			w_strb_q        <= 4'h0;
			out_rate_q      <= `RST_OUT_RATE;
			phase_gate_q    <= 1'b0;
			phase_q         <= `RST_PHASE;
			phase_written_q <= 1'b0;
			ext_ref_q       <= 1'b0;
			sync_q          <= 1'b0;
			deskew_q        <= 1'b0;
			ser_q           <= 16'h0000;
			map_q           <= `RST_MAP1;
		end
		else
		begin
			if (AWVALID & AWREADY)
			begin
				AWREADY   <= 1'b0;
				aw_hold_q <= 1'b1;
				aw_addr_q <= {AWADDR[9:2], 2'b00};
			end
			else if (~aw_hold_q & ~BVALID)
				AWREADY <= 1'b1;
			if (WVALID & WREADY)
			begin
				WREADY   <= 1'b0;
				w_hold_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
			end
			else if (~w_hold_q & ~BVALID)
				WREADY <= 1'b1;
			if (do_write)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				BVALID    <= 1'b1;
				BRESP     <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				if (aw_addr_q == a_rate)
					out_rate_q <= wr_merge[1:0];
				else if (aw_addr_q == a_phase)
				begin
					phase_gate_q <= wr_merge[`BIT_GATE];
					phase_q      <= wr_merge[`BIT_PHASE_HI:`BIT_PHASE_LO];
					ext_ref_q    <= wr_merge[`BIT_EXT_REF];
					if (w_strb_q[0])
						phase_written_q <= 1'b1;
				end
				else if (aw_addr_q == a_test)
				begin
					sync_q   <= wr_merge[`BIT_SYNC];
					deskew_q <= wr_merge[`BIT_DESKEW];
				end
				else if (aw_addr_q == a_ser)
					ser_q <= wr_merge & 16'h9C2D;
				else if (aw_addr_q == a_map)
					map_q <= wr_merge & 16'h8FFF;
			end
			else if (BVALID & BREADY)
				BVALID <= 1'b0;
		end
	end

	// Read channel: data one cycle after the address is taken.
	always @*
	begin
		rd_val = 16'h0000;
		rd_ok  = 1'b1;
		if (ARADDR[9:2] == `IDX_OUT_RATE)
			rd_val = {14'h0000, out_rate_q};
		else if (ARADDR[9:2] == `IDX_PHASE_REF)
			rd_val = {phase_gate_q, 8'h00, phase_written_q ? phase_q : 2'b00, 1'b0,
				ext_ref_q, 3'h0};
		else if (ARADDR[9:2] == `IDX_TEST_PATTERN)
			rd_val = {14'h0000, sync_q, deskew_q};
		else if (ARADDR[9:2] == `IDX_SERIAL_FORMAT)
			rd_val = ser_q;
		else if (ARADDR[9:2] == `IDX_LANE_MAP1)
			rd_val = map_q;
		else if (ARADDR[9:2] == `IDX_STATUS)
			rd_val = {5'h00, LANE_2A_EN, LANE_1B_EN, LANE_1A_EN, two_wire, phase_eff, n_word};
		else
			rd_ok = 1'b0;
	end

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= `RESP_OKAY;
		end
		else if (ARVALID & ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= {16'h0000, rd_val};
			RRESP   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (RVALID & RREADY)
			RVALID <= 1'b0;
		else if (~RVALID)
			ARREADY <= 1'b1;
	end

	// Effective configuration; cleared gates fall back to defaults.
	assign ser_en    = ser_q[`BIT_GATE];
	assign phase_eff = phase_gate_q ? phase_q : `DEF_PHASE;
	assign n_data    = ~ser_en ? `DEF_WIDTH : ser_q[`BIT_W18] ? 5'd18
		: ser_q[`BIT_W16] ? 5'd16 : ser_q[`BIT_W14] ? 5'd14 : `DEF_WIDTH;
	assign pad_eff   = ser_en & ser_q[`BIT_PAD];
	assign msb_eff   = ser_en ? ser_q[`BIT_MSB_FIRST] : `DEF_MSB_FIRST;
	assign twos_eff  = ser_en ? ser_q[`BIT_TWOS] : `DEF_TWOS;
	assign two_wire  = ser_en & ser_q[`BIT_TWO_WIRE];
	assign n_word    = sync_q ? 5'd16 : pad_eff ? n_data + 5'd2 : n_data;
	assign lane_bits = two_wire ? {1'b0, n_word[4:1]} : n_word;

	// Lane sources; the map only counts while its enable is set.
	assign code_1a = map_q[`BIT_GATE] ? map_q[3:0] : `DEF_MAP_1A;
	assign code_1b = map_q[`BIT_GATE] ? map_q[7:4] : `DEF_MAP_1B;
	assign code_2a = map_q[`BIT_GATE] ? map_q[11:8] : `DEF_MAP_2A;

	// Builds one lane word, left aligned so that bit 19 leaves first.
	function [19:0] lane_word;
		input [17:0] smp;
		input        lo;
		reg   [19:0] v;
		reg   [19:0] r;
		integer      i;
		begin
			v = {2'b00, smp} & ~(20'hFFFFF << n_data);
			if (~twos_eff)
				v[n_data - 5'd1] = ~v[n_data - 5'd1];
			if (pad_eff)
				v = v << 2;
			if (sync_q)
				v = `SYNC_WORD;
			else if (deskew_q)
				v = `DESKEW_WORD & ~(20'hFFFFF << n_word);
			if (~msb_eff)
			begin
				for (i = 0; i < 20; i = i + 1)
					r[i] = v[19 - i];
				v = r >> (5'd20 - n_word);
			end
			v = v << (5'd20 - n_word);
			if (two_wire & lo)
				v = v << lane_bits;
			lane_word = v;
		end
	endfunction

	assign word_1a = lane_word(hold_q[code_1a[2:1]], code_1a[0]);
	assign word_1b = lane_word(hold_q[code_1b[2:1]], code_1b[0]);
	assign word_2a = lane_word(hold_q[code_2a[2:1]], code_2a[0]);

	// Sample decimation keeps one sample in 1, 2, 4 or 8.
	assign rate_mask = (out_rate_q == 2'h0) ? 3'h0 : (out_rate_q == 2'h1) ? 3'h1
		: (out_rate_q == 2'h2) ? 3'h3 : 3'h7;

	always @(posedge CLK)
	begin
		if (RESET)
		begin
			rate_cnt_q <= 3'h0;
			hold_q[0]  <= 18'h00000;
			hold_q[1]  <= 18'h00000;
			hold_q[2]  <= 18'h00000;
			hold_q[3]  <= 18'h00000;
		end
		else if (SAMPLE_VALID)
		begin
			rate_cnt_q <= (rate_cnt_q + 3'h1) & rate_mask;
			if (rate_cnt_q == 3'h0)
			begin
				hold_q[0] <= CH1_DATA;
				hold_q[1] <= CH2_DATA;
				hold_q[2] <= CH3_DATA;
				hold_q[3] <= CH4_DATA;
			end
		end
	end

	// Link timing: rising edges of the synchronised reference step the serializer.
	bit_sync link_sync
	(
		.clk    (CLK),
		.reset  (RESET),
		.din    (LINK_CLK),
		.dout_q (lk_s)
	);

	assign tick  = lk_s & ~lk_prev_q;
	assign load  = (cnt_q == 5'd0);
	assign cnt_d = (cnt_q + 5'd1 >= lane_bits) ? 5'd0 : cnt_q + 5'd1;

	// The bit clock copy is delayed in steps; this trades pin phase accuracy
	// for staying wholly in one clock domain.
	always @(posedge CLK)
	begin
		if (RESET)
		begin
			lk_prev_q        <= 1'b0;
			lk_pipe_q        <= 7'h00;
			cnt_q            <= 5'd0;
			SERIAL_BIT_CLOCK <= 1'b0;
			FRAME_CLOCK      <= 1'b0;
			LANE_1A_EN       <= 1'b0;
			LANE_1B_EN       <= 1'b0;
			LANE_2A_EN       <= 1'b0;
			EXTERNAL_REFERENCE_SELECT <= 1'b0;
		end
		else
		begin
			lk_prev_q        <= lk_s;
			lk_pipe_q        <= {lk_pipe_q[5:0], lk_s};
			SERIAL_BIT_CLOCK <= (phase_eff == 2'h0) ? lk_s
				: lk_pipe_q[phase_eff * `PHASE_STEP_CYCLES - 1];
			LANE_1A_EN <= ~(map_q[`BIT_GATE] & code_1a[3]);
			LANE_1B_EN <= ~(map_q[`BIT_GATE] & code_1b[3]);
			LANE_2A_EN <= ~(map_q[`BIT_GATE] & code_2a[3]);
			EXTERNAL_REFERENCE_SELECT <= phase_gate_q & ext_ref_q;
			if (tick)
			begin
				cnt_q <= cnt_d;
				if (two_wire)
				begin
					if (load)
						FRAME_CLOCK <= ~FRAME_CLOCK;
				end
				else
					FRAME_CLOCK <= (cnt_q < {1'b0, lane_bits[4:1]});
			end
		end
	end

	lane_shifter shift_1a
	(
		.clk   (CLK),
		.reset (RESET),
		.tick  (tick),
		.load  (load),
		.word  (word_1a),
		.bit_q (LANE_1A)
	);

	lane_shifter shift_1b
	(
		.clk   (CLK),
		.reset (RESET),
		.tick  (tick),
		.load  (load),
		.word  (word_1b),
		.bit_q (LANE_1B)
	);

	lane_shifter shift_2a
	(
		.clk   (CLK),
		.reset (RESET),
		.tick  (tick),
		.load  (load),
		.word  (word_2a),
		.bit_q (LANE_2A)
	);

endmodule // serial_output_format

`default_nettype wire

// ### serial_output_format_sva.sv
`timescale 1ns/10ps
`default_nettype none
module serial_output_format_sva
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RESET,
	// Register bus
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0]  RRESP,
	input wire logic        RVALID,
	input wire logic        RREADY,
	// Lane driver
	input wire logic        LANE_1A_EN
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_b_answer;
		AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_r_answer;
		ARVALID && ARREADY |=> RVALID;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_w_busy;
		BVALID |-> !AWREADY && !WREADY;
	endproperty
	a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
	property p_ar_busy;
		RVALID |-> !ARREADY;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	property p_rdata_narrow;
		RVALID |-> RDATA[31:16] == 16'h0000 && (RRESP == 2'h0 || RRESP == 2'h2);
	endproperty
	a_rdata_narrow: assert property (p_rdata_narrow) else $error("bad read answer");
	property p_b_release;
		BVALID && BREADY |=> !BVALID ##1 AWREADY && WREADY;
	endproperty
	a_b_release: assert property (p_b_release) else $error("write channel stuck");
	property p_reset_quiet;
		disable iff (1'b0) RESET |=> !BVALID && !RVALID && !LANE_1A_EN;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live in reset");
	property p_reset_exit;
		$fell(RESET) |=> AWREADY && WREADY && ARREADY && LANE_1A_EN;
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("no default after reset");
endmodule // serial_output_format_sva
bind serial_output_format serial_output_format_sva i_sva
(
	.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
	.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
	.LANE_1A_EN(LANE_1A_EN)
);
`default_nettype wire

// ### lane_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module lane_receiver
(
	// Serial capture
	input wire logic        bit_clk,
	input wire logic        frame,
	input wire logic        lane,
	// Search control
	input wire logic        clr,
	input wire logic [15:0] want,
	output logic            hit
);
	logic [15:0] win_q;
	logic [15:0] frm_q;
	logic [4:0]  cnt_q;
	// A hit needs sixteen fresh bits, so stale bits of the old setting cannot match.
	// A single-lane word only counts where the frame clock is high for its first half.
	always @(posedge bit_clk)
	begin
		win_q <= {win_q[14:0], lane};
		frm_q <= {frm_q[14:0], frame};
		cnt_q <= clr ? 5'h00 : cnt_q + {4'h0, cnt_q != 5'h10};
		hit   <= !clr && (hit || (cnt_q == 5'h10 && win_q == want && frm_q == 16'hFF00));
	end
endmodule // lane_receiver
`default_nettype wire

// ### serial_output_format_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_output_format_tb_top;
	logic        CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic        SAMPLE_VALID = 1'b0, LINK_CLK = 1'b0, clr = 1'b1;
	logic [9:0]  AWADDR = 10'h000, ARADDR = 10'h000;
	logic [31:0] WDATA = 32'h0, v;
	logic [3:0]  WSTRB = 4'h0;
	logic [17:0] CH1_DATA = 18'h0, CH2_DATA = 18'h0, CH3_DATA = 18'h0, CH4_DATA = 18'h0;
	logic [15:0] want = 16'h0, want_1b = 16'h0, want_2a = 16'h0;
	logic [15:0] fw [6] = '{16'h1421, 16'h8400, 16'h8420, 16'h9000, 16'h8800, 16'h8401};
	logic [7:0]  fs [6] = '{8'h10, 8'h0E, 8'h10, 8'h12, 8'h10, 8'h8E};
	wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, sbc, frc, l1a, l1b, l2a;
	wire         e1a, e1b, e2a, xref, hit, hit_1b, hit_2a;
	wire  [1:0]  BRESP, RRESP;
	wire  [31:0] RDATA;
	integer      errors = 0, checks_done = 0, cycles = 0, i, seed = 32'h1C88B158;
	serial_output_format i_dut
	(
		.CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.SAMPLE_VALID(SAMPLE_VALID), .CH1_DATA(CH1_DATA), .CH2_DATA(CH2_DATA),
		.CH3_DATA(CH3_DATA), .CH4_DATA(CH4_DATA), .LINK_CLK(LINK_CLK),
		.SERIAL_BIT_CLOCK(sbc), .FRAME_CLOCK(frc), .LANE_1A(l1a), .LANE_1B(l1b), .LANE_2A(l2a),
		.LANE_1A_EN(e1a), .LANE_1B_EN(e1b), .LANE_2A_EN(e2a), .EXTERNAL_REFERENCE_SELECT(xref)
	);
	lane_receiver i_rx (.bit_clk(sbc), .frame(frc), .lane(l1a), .clr(clr), .want(want), .hit(hit));
	lane_receiver i_rx_1b
	(
		.bit_clk(sbc), .frame(frc), .lane(l1b), .clr(clr), .want(want_1b), .hit(hit_1b)
	);
	lane_receiver i_rx_2a
	(
		.bit_clk(sbc), .frame(frc), .lane(l2a), .clr(clr), .want(want_2a), .hit(hit_2a)
	);
	always #20 CLK = ~CLK;
	initial
	begin
		#7;
		forever #160 LINK_CLK = ~LINK_CLK;
	end
	always @(posedge CLK)
	begin
		cycles <= cycles + 1;
		SAMPLE_VALID <= !RESET && cycles[1:0] == 2'h0;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			conclude;
		end
	end
	function logic [1:0] resp_of(input [9:0] a);
		resp_of = (a == 10'h0E0 || a == 10'h108 || a == 10'h114 || a == 10'h118
			|| a == 10'h140 || a == 10'h180) ? 2'h0 : 2'h2;
	endfunction
	function logic [15:0] exp_word(input [17:0] s, input tw, input msb, input pad);
		logic [15:0] w;
		logic [15:0] r;
		w = pad ? {s[13:0], 2'b00} : s[15:0];
		w[15] = w[15] ^ !tw;
		for (int k = 0; k < 16; k++)
			r[k] = w[15 - k];
		exp_word = msb ? w : r;
	endfunction
	task chk(input [31:0] g, input [31:0] e, input [31:0] m);
		checks_done = checks_done + 1;
		if ((g & m) !== (e & m))
		begin
			errors = errors + 1;
			$display("MISMATCH at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wx(input [9:0] a, input [31:0] d);
		@(posedge CLK);
		AWADDR <= a;
		AWVALID <= 1'b1;
		WDATA <= d;
		WSTRB <= 4'h3;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
		end
		while (!BVALID);
		BREADY <= 1'b0;
		chk({30'h0, BRESP}, {30'h0, resp_of(a)}, 32'h3);
	endtask
	task rx(input [9:0] a, input [31:0] e, input [31:0] m);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
		end
		while (!RVALID);
		RREADY <= 1'b0;
		chk(RDATA, e, m);
		chk({30'h0, RRESP}, {30'h0, resp_of(a)}, 32'h3);
	endtask
	// The far end has no word alignment, so the expected word is searched for.
	task stream(input [15:0] e, input [15:0] e_1b, input [15:0] e_2a);
		integer n;
		clr <= 1'b1;
		want <= e;
		want_1b <= e_1b;
		want_2a <= e_2a;
		repeat (24) @(posedge CLK);
		clr <= 1'b0;
		for (n = 0; n < 600 && {hit_2a, hit_1b, hit} !== 3'h7; n++)
			@(posedge CLK);
		chk({29'h0, hit_2a, hit_1b, hit}, 32'h7, 32'h7);
	endtask
	task data_stream(input [17:0] a, input [17:0] b, input [17:0] c, input tw, msb, pad);
		stream(exp_word(a, tw, msb, pad), exp_word(b, tw, msb, pad), exp_word(c, tw, msb, pad));
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		rx(10'h108, 32'h0, 32'hFFFFFFFF);
		rx(10'h180, 32'h750, 32'h7FF);
		rx(10'h3FC, 32'h0, 32'hFFFFFFFF);
		wx(10'h3FC, 32'hFFFF);
		for (i = 0; i < 4; i++)
		begin
			wx(10'h0E0, i);
			rx(10'h0E0, i, 32'h3);
		end
		wx(10'h108, 32'h48);
		rx(10'h108, 32'h48, 32'hFFFFFFFF);
		chk({31'h0, xref}, 32'h0, 32'h1);
		rx(10'h180, 32'h40, 32'h60);
		repeat (3)
		begin
			v = $random(seed) & 32'h60;
			wx(10'h108, 32'h8008 | v);
			rx(10'h108, 32'h8008 | v, 32'hFFFFFFFF);
			chk({31'h0, xref}, 32'h1, 32'h1);
			rx(10'h180, v, 32'h60);
		end
		wx(10'h108, 32'h8040);
		for (i = 0; i < 6; i++)
		begin
			wx(10'h118, {16'h0, fw[i]});
			rx(10'h180, {24'h0, fs[i]}, 32'h9F);
		end
		wx(10'h140, 32'h8);
		rx(10'h180, 32'h700, 32'h700);
		wx(10'h140, 32'h8298);
		repeat (2) @(posedge CLK);
		chk({29'h0, e2a, e1b, e1a}, 32'h4, 32'h7);
		v = $random(seed);
		CH1_DATA <= 18'h00013;
		CH2_DATA <= v[17:0];
		CH3_DATA <= 18'h00025;
		CH4_DATA <= v[31:14];
		wx(10'h140, 32'h0);
		wx(10'h118, 32'h8808);
		wx(10'h114, 32'h2);
		stream(16'hFF00, 16'hFF00, 16'hFF00);
		wx(10'h114, 32'h1);
		stream(16'hAAAA, 16'hAAAA, 16'hAAAA);
		wx(10'h114, 32'h0);
		data_stream(CH1_DATA, CH1_DATA, CH2_DATA, 1'b0, 1'b1, 1'b0);
		wx(10'h118, 32'h880C);
		data_stream(CH1_DATA, CH1_DATA, CH2_DATA, 1'b1, 1'b1, 1'b0);
		wx(10'h118, 32'h8804);
		data_stream(CH1_DATA, CH1_DATA, CH2_DATA, 1'b1, 1'b0, 1'b0);
		wx(10'h118, 32'h842C);
		data_stream(CH1_DATA, CH1_DATA, CH2_DATA, 1'b1, 1'b1, 1'b1);
		wx(10'h118, 32'h880C);
		wx(10'h140, 32'h8604);
		data_stream(CH3_DATA, CH1_DATA, CH4_DATA, 1'b1, 1'b1, 1'b0);
		conclude;
	end
endmodule // serial_output_format_tb_top
`default_nettype wire
